/* rtl/auds_ctrl.sv */
// Module: controller end that issues one unlatch request per command
`timescale 1ns/1ps
`default_nettype none

module auds_ctrl
  import auds_pkg::*;
(
  input  wire logic       clk_in,       // 20 MHz clock
  input  wire logic       reset_in,     // Sync reset, high
  input  wire logic       clk_en_in,    // Freezes state low
  auds_link_if.ctrl       link,         // Request link
  input  wire logic       cmd_valid_in, // Start one request
  input  wire logic [7:0] cmd_slot_in,  // Target slot
  input  wire logic [7:0] cmd_class_in, // Class
  input  wire logic [7:0] cmd_inst_in,  // Instance (channel + 1)
  input  wire logic [7:0] cmd_attr_in,  // Alarm or zero for all
  output logic            cmd_ready_out,// Accepts a command
  output logic            done_out,     // Reply pulse
  output auds_status_t    status_out    // Reply status
);

  typedef enum logic [1:0] {
    AUDS_C_IDLE = 2'b00, // No request
    AUDS_C_SEND = 2'b01, // Request held
    AUDS_C_WAIT = 2'b11  // Awaiting reply
  } auds_ctrl_state_t;

  auds_ctrl_state_t state, next_state;   // Controller state
  logic [7:0]       slot, next_slot;     // Held slot
  logic [7:0]       cls, next_cls;       // Held class
  logic [7:0]       inst, next_inst;     // Held instance
  logic [7:0]       attr, next_attr;     // Held attribute
  logic             done, next_done;     // Reply pulse
  auds_status_t     st, next_st;         // Reply status

  ////////////////////////////////////////////////////////////////////////////
  // Link drive; one outstanding request since one serves one alarm
  always_comb begin
    link.req_valid  = (state == AUDS_C_SEND);
    // RQ11 address by slot
    link.slot       = slot;
    // RQ1 fixed unlatch code
    link.service    = AUDS_SVC_UNLATCH;
    link.class_code = cls;
    link.inst_code  = inst;
    link.attribute  = attr;
    cmd_ready_out   = (state == AUDS_C_IDLE);
    done_out        = done;
    status_out      = st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    next_slot  = slot;
    next_cls   = cls;
    next_inst  = inst;
    next_attr  = attr;
    next_done  = 1'b0;
    next_st    = st;
    unique case (state)
      AUDS_C_IDLE: begin
        // RQ8 one channel, one alarm
        if (cmd_valid_in) begin
          next_slot  = cmd_slot_in;
          next_cls   = cmd_class_in;
          next_inst  = cmd_inst_in;
          next_attr  = cmd_attr_in;
          next_state = AUDS_C_SEND;
        end
      end
      AUDS_C_SEND: begin
        if (link.req_ready) begin
          next_state = AUDS_C_WAIT;
        end
      end
      AUDS_C_WAIT: begin
        if (link.rsp_valid) begin
          next_done  = 1'b1;
          next_st    = link.rsp_status;
          next_state = AUDS_C_IDLE;
        end
      end
      default: begin
        next_state = AUDS_C_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= AUDS_C_IDLE;
      slot  <= 8'h00;
      cls   <= 8'h00;
      inst  <= 8'h00;
      attr  <= 8'h00;
      done  <= 1'b0;
      st    <= AUDS_ST_OK;
    end else if (clk_en_in) begin
      state <= next_state;
      slot  <= next_slot;
      cls   <= next_cls;
      inst  <= next_inst;
      attr  <= next_attr;
      done  <= next_done;
      st    <= next_st;
    end
  end

endmodule : auds_ctrl

`default_nettype wire

/* rtl/auds_decode.sv */
// Module: maps a request's class, instance and attribute onto a clear mask
`timescale 1ns/1ps
`default_nettype none

module auds_decode
  import auds_pkg::*;
#(
  parameter int CH_MAX = 16 // Channels the latch array holds
) (
  input  wire logic [7:0]        class_in,     // Object class
  input  wire logic [7:0]        instance_in,  // Object instance
  input  wire logic [7:0]        attribute_in, // Alarm selector
  input  wire auds_layout_t      layout_in,    // Channel layout
  output logic [CH_MAX-1:0]      ch_sel_out,   // One-hot channel select
  output logic [AUDS_ALM_W-1:0]  alm_sel_out,  // Alarms to clear
  output logic                   valid_out     // Target exists
);

  logic [7:0] ch_num;   // Instance less one
  logic [7:0] ch_cnt;   // Channels present in this layout
  logic       class_ok; // Class matches layout
  logic       ch_ok;    // Instance in range

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode
  always_comb begin
    ch_num   = instance_in - AUDS_INST_BASE;
    ch_cnt   = 8'h00;
    class_ok = 1'b0;
    unique case (layout_in)
      // RQ3 six-channel numbering
      AUDS_LAYOUT_IN6: begin
        ch_cnt   = AUDS_CH6;
        class_ok = (class_in == AUDS_CLASS_IN);
      end
      // RQ4 eight-channel numbering
      AUDS_LAYOUT_IN8: begin
        ch_cnt   = AUDS_CH8;
        class_ok = (class_in == AUDS_CLASS_IN);
      end
      // RQ10 single-ended sixteen has no target
      AUDS_LAYOUT_IN16S: begin
        ch_cnt   = 8'h00;
        class_ok = 1'b0;
      end
      // RQ2 output class selects output channels
      AUDS_LAYOUT_OUT: begin
        ch_cnt   = AUDS_CH6;
        class_ok = (class_in == AUDS_CLASS_OUT);
      end
    endcase
    // Instance zero wraps to 8'hFF, so it fails the range test too
    ch_ok = (ch_num < ch_cnt) && (32'(ch_num) < CH_MAX);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm decode
  always_comb begin
    alm_sel_out = '0;
    if (attribute_in == AUDS_ATTR_ALL) begin
      // RQ7 zero clears all alarms
      alm_sel_out = '1;
    end else if (layout_in == AUDS_LAYOUT_OUT) begin
      // RQ6 output alarm selection
      unique case (attribute_in)
        AUDS_ATTR_OUT_HI:   alm_sel_out[AUDS_BIT_HI]   = 1'b1;
        AUDS_ATTR_OUT_LO:   alm_sel_out[AUDS_BIT_LO]   = 1'b1;
        AUDS_ATTR_OUT_RAMP: alm_sel_out[AUDS_BIT_RATE] = 1'b1;
        default:            alm_sel_out = '0;
      endcase
    end else begin
      // RQ5 input alarm selection
      unique case (attribute_in)
        AUDS_ATTR_IN_HH:   alm_sel_out[AUDS_BIT_HH]   = 1'b1;
        AUDS_ATTR_IN_HI:   alm_sel_out[AUDS_BIT_HI]   = 1'b1;
        AUDS_ATTR_IN_LO:   alm_sel_out[AUDS_BIT_LO]   = 1'b1;
        AUDS_ATTR_IN_LL:   alm_sel_out[AUDS_BIT_LL]   = 1'b1;
        AUDS_ATTR_IN_RATE: alm_sel_out[AUDS_BIT_RATE] = 1'b1;
        default:           alm_sel_out = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel one-hot and overall verdict
  always_comb begin
    ch_sel_out = '0;
    if (ch_ok) begin
      ch_sel_out[ch_num[$clog2(CH_MAX)-1:0]] = 1'b1;
    end
    // RQ14 unknown target rejected
    valid_out = class_ok && ch_ok && (alm_sel_out != '0);
  end

endmodule : auds_decode

`default_nettype wire

/* rtl/auds_dev.sv */
// Module: I/O module end that holds alarm latches and serves unlatch requests
//
// Behaviour
// RQ1 - Code 4B is the unlatch command
// RQ2 - Class 0A inputs, 0B outputs
// RQ3 - Six-channel: instance 1..6 is channel 0..5
// RQ4 - Eight-channel: instance 1..8 is channel 0..7
// RQ5 - Input attribute picks one of five alarms
// RQ6 - Output attribute picks high, low or ramp
// RQ7 - Attribute zero clears every channel alarm
// RQ8 - Controller sends one request per alarm, channel
// RQ9 - Error reply when latching is off
// RQ10 - Single-ended sixteen mode has no targets
// RQ11 - Controller addresses module by slot
// RQ12 - One clear per request; resample may reset
// RQ13 - Sampling work takes priority over requests
// RQ14 - Unsupported target: error, latches unchanged
// RQ15 - Request carries no payload beyond fields
//
// One request at a time; replies wait for free sampling time
`timescale 1ns/1ps
`default_nettype none

module auds_dev
  import auds_pkg::*;
#(
  parameter int         CH_MAX  = 16,     // Channels held in latch array
  parameter logic [7:0] MY_SLOT = 8'h01   // Chassis slot of this module
) (
  input  wire logic                        clk_in,        // 20 MHz clock
  input  wire logic                        reset_in,      // Sync reset, high
  input  wire logic                        clk_en_in,     // Freezes state low
  auds_link_if.dev                         link,          // Request link
  input  wire auds_layout_t                layout_in,     // Channel layout
  input  wire logic                        latch_en_in,   // Latching enabled
  input  wire logic                        sample_busy_in,// Sampling underway
  input  wire logic [CH_MAX*AUDS_ALM_W-1:0] alarm_set_in, // Per-sample alarms
  output logic [CH_MAX*AUDS_ALM_W-1:0]     alarm_out      // Alarm latches
);

  // Request handler states, Gray along idle -> check -> reply
  typedef enum logic [1:0] {
    AUDS_IDLE  = 2'b00, // Waiting for a request
    AUDS_CHECK = 2'b01, // Request captured, waiting for a free slot
    AUDS_REPLY = 2'b11  // Reply pulse
  } auds_dev_state_t;
  // Code 2'b10 is unused and recovers to idle

  auds_dev_state_t             state, next_state;     // Handler state

  // Captured request fields
  logic [7:0]                  svc, next_svc;         // Captured service
  logic [7:0]                  cls, next_cls;         // Captured class
  logic [7:0]                  inst, next_inst;       // Captured instance
  logic [7:0]                  attr, next_attr;       // Captured attribute

  // Reply and latch state
  auds_status_t                status, next_status;   // Reply status
  logic [CH_MAX*AUDS_ALM_W-1:0] latch, next_latch;    // Alarm latches

  // Decoder results
  logic [CH_MAX-1:0]           ch_sel;                // Decoded channel
  logic [AUDS_ALM_W-1:0]       alm_sel;               // Decoded alarms
  logic                        tgt_ok;                // Target exists
  logic                        do_clear;              // Clear this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Target decode on the captured fields
  auds_decode #(
    .CH_MAX (CH_MAX)
  ) u_decode (
    .class_in     (cls),
    .instance_in  (inst),
    .attribute_in (attr),
    .layout_in    (layout_in),
    .ch_sel_out   (ch_sel),
    .alm_sel_out  (alm_sel),
    .valid_out    (tgt_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request handshake: take only when idle; other slots' traffic is ignored
  always_comb begin
    // Ready only while idle
    link.req_ready = (state == AUDS_IDLE);
    // One-cycle reply pulse
    link.rsp_valid = (state == AUDS_REPLY);
    // Status register stands between replies
    link.rsp_status = status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handler next state
  always_comb begin
    next_state  = state;
    next_svc    = svc;
    next_cls    = cls;
    next_inst   = inst;
    next_attr   = attr;
    next_status = status;
    do_clear    = 1'b0;

    unique case (state)
      AUDS_IDLE: begin
        // RQ11 only our slot is acted on
        if (link.req_valid && link.slot == MY_SLOT) begin
          // RQ15 only the four fields are stored
          next_svc   = link.service;
          next_cls   = link.class_code;
          next_inst  = link.inst_code;
          next_attr  = link.attribute;
          next_state = AUDS_CHECK;
        end
      end

      AUDS_CHECK: begin
        // RQ13 wait out sampling work
        if (!sample_busy_in) begin
          // Free slot: answer now
          next_state = AUDS_REPLY;
          // RQ1 service code check
          if (svc != AUDS_SVC_UNLATCH) begin
            next_status = AUDS_ST_BADSVC;
          // RQ9 latching off gives error
          end else if (!latch_en_in) begin
            next_status = AUDS_ST_NOLATCH;
          // RQ14 bad target, latches kept
          end else if (!tgt_ok) begin
            next_status = AUDS_ST_BADPATH;
          end else begin
            // RQ12 single clear per request
            do_clear    = 1'b1;
            next_status = AUDS_ST_OK;
          end
        end
      end

      AUDS_REPLY: begin
        // Pulse done, next request may follow
        next_state = AUDS_IDLE;
      end

      default: begin
        // Unused code recovers to idle
        next_state = AUDS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latch next value: a fresh sample alarm wins over a clear in one cycle
  always_comb begin
    next_latch = latch;

    // Clear the chosen alarms of the chosen channel
    for (int c = 0; c < CH_MAX; c++) begin
      if (do_clear && ch_sel[c]) begin
        next_latch[c*AUDS_ALM_W +: AUDS_ALM_W] =
          latch[c*AUDS_ALM_W +: AUDS_ALM_W] & ~alm_sel;
      end
    end

    // Without latching the array just follows the samples
    if (latch_en_in) begin
      next_latch = next_latch | alarm_set_in;
    end else begin
      next_latch = alarm_set_in;
    end

    // Output is the registered latch array
    alarm_out = latch;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handler registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // Reset: idle, status OK
      state  <= AUDS_IDLE;
      svc    <= 8'h00;
      cls    <= 8'h00;
      inst   <= 8'h00;
      attr   <= 8'h00;
      status <= AUDS_ST_OK;
    end else if (clk_en_in) begin
      // Enable low holds all state
      state  <= next_state;
      svc    <= next_svc;
      cls    <= next_cls;
      inst   <= next_inst;
      attr   <= next_attr;
      status <= next_status;
    end
  end

  // Latch registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      latch <= '0;
    end else if (clk_en_in) begin
      latch <= next_latch;
    end
  end

endmodule : auds_dev

`default_nettype wire

/* rtl/auds_link_if.sv */
// Interface: request and reply link between controller and I/O module
`timescale 1ns/1ps
`default_nettype none

interface auds_link_if;
  import auds_pkg::*;
  logic         req_valid;  // Request held by controller
  logic         req_ready;  // Module takes the request this cycle
  logic [7:0]   slot;       // Target slot position
  logic [7:0]   service;    // Service code
  logic [7:0]   class_code; // Object class
  logic [7:0]   inst_code;  // Object instance (channel + 1)
  logic [7:0]   attribute;  // Alarm selector, zero for all
  logic         rsp_valid;  // One-cycle reply pulse
  auds_status_t rsp_status; // Reply status

  // Controller end
  modport ctrl (output req_valid, slot, service, class_code, inst_code,
                attribute, input req_ready, rsp_valid, rsp_status);
  // Module end
  modport dev (input req_valid, slot, service, class_code, inst_code,
               attribute, output req_ready, rsp_valid, rsp_status);
endinterface : auds_link_if

`default_nettype wire

/* rtl/auds_pkg.sv */
// Package: shared codes, field widths and types of the unlatch-service link
package auds_pkg;

  // Service, class and attribute codes (all 8-bit)
  localparam logic [7:0] AUDS_SVC_UNLATCH   = 8'h4B; // Unlatch command
  localparam logic [7:0] AUDS_CLASS_IN      = 8'h0A; // Input channel object
  localparam logic [7:0] AUDS_CLASS_OUT     = 8'h0B; // Output channel object
  localparam logic [7:0] AUDS_ATTR_ALL      = 8'h00; // All alarms of channel
  localparam logic [7:0] AUDS_ATTR_IN_HH    = 8'h6E; // Input high-high
  localparam logic [7:0] AUDS_ATTR_IN_HI    = 8'h6C; // Input high
  localparam logic [7:0] AUDS_ATTR_IN_LO    = 8'h6B; // Input low
  localparam logic [7:0] AUDS_ATTR_IN_LL    = 8'h6D; // Input low-low
  localparam logic [7:0] AUDS_ATTR_IN_RATE  = 8'h6F; // Input rate
  localparam logic [7:0] AUDS_ATTR_OUT_HI   = 8'h6F; // Output high limit
  localparam logic [7:0] AUDS_ATTR_OUT_LO   = 8'h6E; // Output low limit
  localparam logic [7:0] AUDS_ATTR_OUT_RAMP = 8'h70; // Output ramp

  // Instance numbering starts one above the channel number
  localparam logic [7:0] AUDS_INST_BASE     = 8'h01;

  // Alarm bit positions inside one channel's latch vector
  localparam int AUDS_ALM_W     = 5;
  localparam int AUDS_BIT_HH    = 0; // Input high-high
  localparam int AUDS_BIT_HI    = 1; // Input high / output high limit
  localparam int AUDS_BIT_LO    = 2; // Input low / output low limit
  localparam int AUDS_BIT_LL    = 3; // Input low-low
  localparam int AUDS_BIT_RATE  = 4; // Input rate / output ramp

  // Channel layouts the device can be built as
  typedef enum logic [1:0] {
    AUDS_LAYOUT_IN6   = 2'h0, // Six input channels
    AUDS_LAYOUT_IN8   = 2'h1, // Eight input channels (or 8 differential)
    AUDS_LAYOUT_IN16S = 2'h2, // Sixteen single-ended, no unlatch targets
    AUDS_LAYOUT_OUT   = 2'h3  // Output module
  } auds_layout_t;

  localparam logic [7:0] AUDS_CH6  = 8'h06; // Channels of six-channel layout
  localparam logic [7:0] AUDS_CH8  = 8'h08; // Channels of eight-channel layout

  // Reply status
  typedef enum logic [1:0] {
    AUDS_ST_OK      = 2'h0, // Alarm(s) cleared
    AUDS_ST_NOLATCH = 2'h1, // Module not set to latch alarms
    AUDS_ST_BADPATH = 2'h2, // Class, instance or attribute unsupported
    AUDS_ST_BADSVC  = 2'h3  // Service code not understood
  } auds_status_t;

endpackage : auds_pkg

/* tb/auds_link_asserts.sv */
// Checker: timing and status relations on the unlatch request link
`timescale 1ns/1ps
`default_nettype none

module auds_link_asserts
  import auds_pkg::*;
#(
  parameter logic [7:0] MY_SLOT = 8'h01  // Slot the module answers to
) (
  input wire logic         clk_in,      // Link clock
  input wire logic         reset_in,    // Sync reset, high
  input wire logic         req_valid,   // Request held
  input wire logic         req_ready,   // Module idle
  input wire logic [7:0]   slot,        // Target slot
  input wire logic [7:0]   service,     // Service code
  input wire logic [7:0]   class_code,  // Object class
  input wire logic [7:0]   inst_code,   // Object instance
  input wire logic [7:0]   attribute,   // Alarm selector
  input wire logic         rsp_valid,   // Reply pulse
  input wire auds_status_t rsp_status   // Reply status
);
  // Longest reply wait; the bench keeps busy stretches far shorter
  localparam int RSP_MAX = 40;
  logic       take;                       // Request taken this edge
  logic [7:0] cap_cls, cap_inst, cap_att; // Target of request in flight
  logic [7:0] next_cls, next_inst, next_att;
  logic       bad_target;                 // Target can never be valid

  assign take = req_valid && req_ready && slot == MY_SLOT;

  // Capture the target at the take so the reply can be judged
  always_comb begin
    next_cls  = take ? class_code : cap_cls;
    next_inst = take ? inst_code : cap_inst;
    next_att  = take ? attribute : cap_att;
  end
  always_ff @(posedge clk_in) begin
    cap_cls  <= next_cls;
    cap_inst <= next_inst;
    cap_att  <= next_att;
  end

  // No layout has more than eight channels or other attributes
  always_comb begin
    bad_target = cap_inst == 8'h00 || cap_inst > 8'h08;
    if (cap_cls == AUDS_CLASS_IN) begin
      bad_target = bad_target || !(cap_att inside {8'h00, [8'h6B:8'h6F]});
    end else if (cap_cls == AUDS_CLASS_OUT) begin
      bad_target = bad_target || cap_inst > 8'h06 ||
                   !(cap_att inside {8'h00, 8'h6E, 8'h6F, 8'h70});
    end else begin
      bad_target = 1'b1;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////////////////////
  // fixed service code
  svc_fixed_a: assert property (req_valid |-> service == AUDS_SVC_UNLATCH)
    else $error("request service code is not unlatch");
  no_badsvc_a: assert property (rsp_valid |-> rsp_status != AUDS_ST_BADSVC)
    else $error("unlatch code answered as unknown service");
  req_hold_a: assert property (req_valid && !req_ready |=> req_valid &&
    $stable(class_code) && $stable(inst_code) && $stable(attribute))
    else $error("request changed before it was taken");
  reply_bound_a: assert property (take |-> ##1 !rsp_valid ##[1:RSP_MAX] rsp_valid)
    else $error("reply early or missing");
  refuse_a: assert property ((take || (!req_ready && !rsp_valid)) |=>
    !req_ready)
    else $error("second request accepted before reply");
  one_reply_a: assert property (rsp_valid |=> !rsp_valid && req_ready)
    else $error("reply longer than one cycle or no return to idle");
  reply_cause_a: assert property (rsp_valid |-> !$past(req_ready))
    else $error("reply without a request in flight");
  bad_path_a: assert property (rsp_valid && bad_target |->
    rsp_status inside {AUDS_ST_NOLATCH, AUDS_ST_BADPATH})
    else $error("unsupported target answered as cleared");
  status_hold_a: assert property ($changed(rsp_status) |-> rsp_valid)
    else $error("reply status changed outside a reply");

  // Main outcomes seen on the link
  cover property (rsp_valid && rsp_status == AUDS_ST_OK);
  cover property (rsp_valid && rsp_status == AUDS_ST_NOLATCH);
  cover property (rsp_valid && rsp_status == AUDS_ST_BADPATH);
endmodule : auds_link_asserts

`default_nettype wire

/* tb/tb_top.sv */
// Testbench: controller and module ends joined, plus a raw second link
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import auds_pkg::*;
  localparam logic [7:0] SLOT = 8'h01;  // Slot of both modules
  localparam int         AW   = 16 * AUDS_ALM_W;
  typedef struct packed {
    auds_status_t  st;   // Expected reply
    logic [AW-1:0] alm;  // Expected latches after reply
  } auds_tb_exp_t;

  logic          clk, rst, cmd_valid, cmd_ready, done, latch_en;
  logic          busy_mode, busy;
  logic [7:0]    cmd_cls, cmd_inst, cmd_attr;
  auds_status_t  status;
  auds_layout_t  layout;
  logic [AW-1:0] alm_set, alm, alm2;
  logic [31:0]   lfsr = 32'h00016403;  // Fixed seed
  logic [31:0]   r;
  logic [7:0]    attrs [8] = '{8'h00, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F,
                               8'h70, 8'h71};
  int            fails, check_count;
  int            cyc = 0;
  auds_tb_exp_t  exp_q [$];  // Notes of the driver, oldest first

  auds_link_if l1 ();  // Controller to module
  auds_link_if l2 ();  // Bench to second module, for faulty requests

  auds_ctrl i_auds_ctrl (.clk_in(clk), .reset_in(rst), .clk_en_in(1'b1),
    .link(l1), .cmd_valid_in(cmd_valid), .cmd_slot_in(SLOT),
    .cmd_class_in(cmd_cls), .cmd_inst_in(cmd_inst), .cmd_attr_in(cmd_attr),
    .cmd_ready_out(cmd_ready), .done_out(done), .status_out(status));
  auds_dev #(.CH_MAX(16), .MY_SLOT(SLOT)) i_auds_dev (.clk_in(clk),
    .reset_in(rst), .clk_en_in(1'b1), .link(l1), .layout_in(layout),
    .latch_en_in(latch_en), .sample_busy_in(busy), .alarm_set_in(alm_set),
    .alarm_out(alm));
  auds_dev #(.CH_MAX(16), .MY_SLOT(SLOT)) i_auds_dev_b (.clk_in(clk),
    .reset_in(rst), .clk_en_in(1'b1), .link(l2), .layout_in(layout),
    .latch_en_in(latch_en), .sample_busy_in(busy), .alarm_set_in(alm_set),
    .alarm_out(alm2));
  auds_link_asserts #(.MY_SLOT(SLOT)) i_auds_link_asserts (.clk_in(clk),
    .reset_in(rst), .req_valid(l1.req_valid), .req_ready(l1.req_ready),
    .slot(l1.slot), .service(l1.service), .class_code(l1.class_code),
    .inst_code(l1.inst_code), .attribute(l1.attribute),
    .rsp_valid(l1.rsp_valid), .rsp_status(l1.rsp_status));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Sampling work three cycles in four while enabled
  always @(posedge clk) begin
    cyc <= cyc + 1;
    busy <= #1 busy_mode && cyc[1:0] != 2'h0;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task automatic check(input logic [AW+1:0] seen, input logic [AW+1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("Counts: %0d checks, %0d mismatches", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Outcome of a request worked out from the channel and alarm codes
  function automatic auds_tb_exp_t expect_of(input logic [7:0] c, i, a);
    logic [4:0]   m;
    int           n;
    auds_tb_exp_t e;
    e.alm = latch_en ? {AW{1'b1}} : '0;
    n = layout == AUDS_LAYOUT_IN8 ? 8 : 6;
    m = 5'h00;
    if (c == 8'h0A && layout != AUDS_LAYOUT_OUT) begin
      case (a)
        8'h00: m = 5'h1F;
        8'h6E: m = 5'h01;
        8'h6C: m = 5'h02;
        8'h6B: m = 5'h04;
        8'h6D: m = 5'h08;
        8'h6F: m = 5'h10;
        default: m = 5'h00;
      endcase
    end
    if (c == 8'h0B && layout == AUDS_LAYOUT_OUT) begin
      case (a)
        8'h00: m = 5'h1F;
        8'h6F: m = 5'h02;
        8'h6E: m = 5'h04;
        8'h70: m = 5'h10;
        default: m = 5'h00;
      endcase
    end
    if (!latch_en) e.st = AUDS_ST_NOLATCH;
    else if (m == 5'h00 || i == 8'h00 || i > n || layout == AUDS_LAYOUT_IN16S)
      e.st = AUDS_ST_BADPATH;
    else begin
      e.st = AUDS_ST_OK;
      e.alm[(int'(i) - 1) * 5 +: 5] = ~m;
    end
    return e;
  endfunction : expect_of

  // Sets every latch, then sends one command and waits for its reply
  task automatic send(input logic [7:0] c, i, a);
    int k;
    k = 0;
    @(posedge clk) #1 alm_set = '1;
    @(posedge clk) #1 alm_set = '0;
    exp_q.push_back(expect_of(c, i, a));
    cmd_cls = c;
    cmd_inst = i;
    cmd_attr = a;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk) #1;
      if (++k > 50) begin fails++; end_sim(); end
    end
    cmd_valid = 1'b1;
    @(posedge clk) #1 cmd_valid = 1'b0;
    cmd_inst = ~i;
    while (exp_q.size() != 0) begin
      @(posedge clk) #1;
      if (++k > 80) begin fails++; end_sim(); end
    end
  endtask : send

  // Result watcher: each reply is matched with the oldest note
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) fails++;
      else check({status, alm}, exp_q.pop_front());
    end
  end

  // Raw request on the second link; took says whether a reply is due
  task automatic raw(input logic [7:0] s, v, input logic took,
                     input auds_status_t st);
    int   k;
    logic got;
    got = 1'b0;
    k = 0;
    @(posedge clk) #1 alm_set = '1;
    @(posedge clk) #1 alm_set = '0;
    {l2.slot, l2.service, l2.class_code, l2.inst_code, l2.attribute} =
      {s, v, 8'h0A, 8'h01, 8'h6C};
    l2.req_valid = 1'b1;
    // Hold until an edge finds the module ready
    @(posedge clk);
    while (l2.req_ready !== 1'b1) begin
      @(posedge clk);
      if (++k > 20) begin fails++; end_sim(); end
    end
    #1 l2.req_valid = 1'b0;
    {l2.slot, l2.service, l2.inst_code} = {~s, ~v, 8'hFE};
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (l2.rsp_valid === 1'b1) begin
        got = 1'b1;
        check({l2.rsp_status, alm2}, {st, {AW{1'b1}}});
      end
    end
    if (got !== took) check({2'(got), alm2}, {2'(took), {AW{1'b1}}});
  endtask : raw

  initial begin
    fails = 0;
    check_count = 0;
    rst = 1'b1;
    {cmd_valid, cmd_cls, cmd_inst, cmd_attr, busy_mode} = '0;
    latch_en = 1'b1;
    layout = AUDS_LAYOUT_IN6;
    alm_set = '0;
    {l2.req_valid, l2.slot, l2.service} = '0;
    {l2.class_code, l2.inst_code, l2.attribute} = '0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    // Every layout, every attribute code and the channel boundaries
    for (int l = 0; l < 4; l++) begin
      layout = auds_layout_t'(l);
      foreach (attrs[j]) send(l == 3 ? 8'h0B : 8'h0A, 8'h06, attrs[j]);
      send(8'h0A, 8'h08, 8'h00);
      send(8'h0A, 8'h09, 8'h00);
      send(8'h0A, 8'h00, 8'h00);
      send(8'h0B, 8'h07, 8'h00);
      $display("Test layout %0d done", l);
    end
    // Latching switched off must be refused
    latch_en = 1'b0;
    send(8'h0A, 8'h01, 8'h6C);
    $display("Test latch off done");
    // Random targets while sampling holds the module off
    busy_mode = 1'b1;
    repeat (40) begin
      r = rnd();
      layout = auds_layout_t'(r[1:0]);
      latch_en = r[10] | r[11];
      send(r[2] ? 8'h0B : 8'h0A, {4'h0, r[6:3]}, attrs[r[9:7]]);
    end
    $display("Test random done");
    // Foreign slot ignored, unknown service refused
    latch_en = 1'b1;
    raw(8'h02, 8'h4B, 1'b0, AUDS_ST_OK);
    raw(SLOT, 8'h4C, 1'b1, AUDS_ST_BADSVC);
    $display("Test second link done");
    end_sim();
  end
endmodule : tb_top

`default_nettype wire
